// >>> src/gesture_proximity_test_regs.sv
// gesture, proximity and test-mode register bank with the logic those registers steer
`timescale 1ns/1ps
// Overview of operation
// - orientation bit 0 negates x result
// - orientation bit 1 negates y result
// - orientation bit 2 swaps x and y channels
// - gesture valid only when points reach minimum
// - thresholds are 22 bits, low plus upper
// - trigger kind 0: event on crossing only
// - trigger kind 1: event while beyond threshold
// - test code 0 or unlisted: normal interrupt
// - codes 1-4 route oscillators to interrupt pin
// - seven force bits, reset 0x40, component order
// - force bits 0-5 select register value
// - force bit 6 hands front end to its logic
// - value bit 1 means powered down
module gesture_proximity_test_regs
   import gesture_proximity_test_pkg::*;
#(
   parameter int FAST_LOG2 = FAST_DIV_LOG2,
   parameter int SLOW_LOG2 = SLOW_DIV_LOG2
) (
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   input  wire logic [ADDR_W-1:0]        reg_addr,
   input  wire logic [DATA_W-1:0]        reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic      [DATA_W-1:0]        reg_rdata_q,
   output logic                          reg_rvalid_q,
   input  wire logic                     sample_valid,
   input  wire logic [DATA_W-1:0]        first_x_channel,
   input  wire logic [DATA_W-1:0]        first_y_channel,
   input  wire logic [DATA_W-1:0]        second_x_channel,
   input  wire logic [DATA_W-1:0]        second_y_channel,
   input  wire logic [DATA_W-1:0]        x_result,
   input  wire logic [DATA_W-1:0]        y_result,
   output logic                          sample_out_valid_q,
   output logic      [DATA_W-1:0]        first_x_out_q,
   output logic      [DATA_W-1:0]        first_y_out_q,
   output logic      [DATA_W-1:0]        second_x_out_q,
   output logic      [DATA_W-1:0]        second_y_out_q,
   output logic      [DATA_W-1:0]        x_result_out_q,
   output logic      [DATA_W-1:0]        y_result_out_q,
   output logic      [DATA_W-1:0]        gesture_rate_threshold_q,
   input  wire logic                     gesture_done,
   input  wire logic [LEN_W-1:0]         gesture_points,
   output logic                          gesture_valid_q,
   output logic                          gesture_reject_q,
   input  wire logic                     intensity_valid,
   input  wire logic [THRESH_W-1:0]      intensity,
   output logic      [1:0]               near_enter_event_q,
   output logic      [1:0]               near_exit_event_q,
   input  wire logic                     normal_int,
   input  wire logic                     slow_oscillator,
   input  wire logic                     fast_oscillator,
   output logic                          int_pin_q,
   output logic                          fast_osc_trim_enable_q,
   input  wire logic [PD_COMPONENTS-1:0] fsm_power_down,
   input  wire logic                     fsm_afe_power_down,
   input  wire logic                     afe_logic_power_down,
   output logic      [PD_COMPONENTS-1:0] power_down_q,
   output logic                          afe_power_down_q
);
   function automatic logic [THRESH_W-1:0] threshold_join(input logic [DATA_W-1:0] low,
                                                          input logic [DATA_W-1:0] upper,
                                                          input int lsb);
      threshold_join = {upper[lsb +: UPPER_W], low};
   endfunction

   function automatic logic [DATA_W-1:0] negate(input logic [DATA_W-1:0] value, input logic flip);
      negate = flip ? DATA_W'(-value) : value;
   endfunction

   logic [DATA_W-1:0] gest_rate_d, rdata_d;
   logic [DATA_W-1:0] orient_q, orient_d;
   logic [DATA_W-1:0] enter1_low_q, enter1_low_d;
   logic [DATA_W-1:0] exit1_low_q, exit1_low_d;
   logic [DATA_W-1:0] enter2_low_q, enter2_low_d;
   logic [DATA_W-1:0] exit2_low_q, exit2_low_d;
   logic [DATA_W-1:0] level1_up_q, level1_up_d;
   logic [DATA_W-1:0] level2_up_q, level2_up_d;
   logic [DATA_W-1:0] test_q, test_d;
   logic [DATA_W-1:0] pd_q, pd_d;
   // register file
   always_comb
   begin
      gest_rate_d = gesture_rate_threshold_q;
      orient_d = orient_q;
      enter1_low_d = enter1_low_q;
      exit1_low_d = exit1_low_q;
      enter2_low_d = enter2_low_q;
      exit2_low_d = exit2_low_q;
      level1_up_d = level1_up_q;
      level2_up_d = level2_up_q;
      test_d = test_q;
      pd_d = pd_q;
      if (reg_write)
      begin
         // reserved positions dropped, so a careless host cannot set them
         case (reg_addr)
            ADDR_GEST_RATE:   gest_rate_d = reg_wdata & MASK_FULL;
            ADDR_ORIENT:      orient_d = reg_wdata & MASK_ORIENT;
            ADDR_ENTER1_LOW:  enter1_low_d = reg_wdata;
            ADDR_EXIT1_LOW:   exit1_low_d = reg_wdata;
            ADDR_ENTER2_LOW:  enter2_low_d = reg_wdata;
            ADDR_EXIT2_LOW:   exit2_low_d = reg_wdata;
            ADDR_LEVEL1_UP:   level1_up_d = reg_wdata & MASK_LEVEL1UP;
            ADDR_LEVEL2_UP:   level2_up_d = reg_wdata & MASK_LEVEL2UP;
            ADDR_TEST_SEL:    test_d = reg_wdata & MASK_TEST;
            ADDR_PD_OVERRIDE: pd_d = reg_wdata & MASK_PD;
            default:          ;
         endcase
      end
      rdata_d = '0;
      if (reg_read)
      begin
         case (reg_addr)
            ADDR_GEST_RATE:   rdata_d = gesture_rate_threshold_q;
            ADDR_ORIENT:      rdata_d = orient_q;
            ADDR_ENTER1_LOW:  rdata_d = enter1_low_q;
            ADDR_EXIT1_LOW:   rdata_d = exit1_low_q;
            ADDR_ENTER2_LOW:  rdata_d = enter2_low_q;
            ADDR_EXIT2_LOW:   rdata_d = exit2_low_q;
            ADDR_LEVEL1_UP:   rdata_d = level1_up_q;
            ADDR_LEVEL2_UP:   rdata_d = level2_up_q;
            ADDR_TEST_SEL:    rdata_d = test_q;
            ADDR_PD_OVERRIDE: rdata_d = pd_q;
            default:          rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         gesture_rate_threshold_q <= RESET_ZERO;
         orient_q <= RESET_ZERO;
         enter1_low_q <= RESET_ZERO;
         exit1_low_q <= RESET_ZERO;
         enter2_low_q <= RESET_ZERO;
         exit2_low_q <= RESET_ZERO;
         level1_up_q <= RESET_ZERO;
         level2_up_q <= RESET_ZERO;
         test_q <= RESET_ZERO;
         pd_q <= RESET_PD;
         reg_rdata_q <= '0;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         gesture_rate_threshold_q <= gest_rate_d;
         orient_q <= orient_d;
         enter1_low_q <= enter1_low_d;
         exit1_low_q <= exit1_low_d;
         enter2_low_q <= enter2_low_d;
         exit2_low_q <= exit2_low_d;
         level1_up_q <= level1_up_d;
         level2_up_q <= level2_up_d;
         test_q <= test_d;
         pd_q <= pd_d;
         reg_rdata_q <= rdata_d;
         reg_rvalid_q <= reg_read;
      end
   end

   // thresholds and comparisons
   logic [THRESH_W-1:0] enter_th [2], exit_th [2];
   logic                level_mode;
   logic [1:0]          above_now, below_now, above_q, above_d, below_q, below_d, enter_event_d, exit_event_d;
   assign enter_th[0] = threshold_join(enter1_low_q, level1_up_q, UPPER_ENTER_LSB);
   assign exit_th[0] = threshold_join(exit1_low_q, level1_up_q, UPPER_EXIT_LSB);
   assign enter_th[1] = threshold_join(enter2_low_q, level2_up_q, UPPER_ENTER_LSB);
   assign exit_th[1] = threshold_join(exit2_low_q, level2_up_q, UPPER_EXIT_LSB);
   assign level_mode = level2_up_q[TRIGGER_KIND_BIT];

   always_comb
   begin
      above_d = above_q;
      below_d = below_q;
      enter_event_d = '0;
      exit_event_d = '0;
      for (int k = 0; k < 2; k++)
      begin
         above_now[k] = intensity > enter_th[k];
         below_now[k] = intensity < exit_th[k];
         if (intensity_valid)
         begin
            above_d[k] = above_now[k];
            below_d[k] = below_now[k];
            // crossing needs the previous sample on the other side
            enter_event_d[k] = above_now[k] && (level_mode || !above_q[k]);
            exit_event_d[k] = below_now[k] && (level_mode || !below_q[k]);
         end
      end
   end

   // sample orientation and gesture qualification
   logic              swap, gvalid_d, greject_d;
   logic [DATA_W-1:0] fx_d, fy_d, sx_d, sy_d, xr_d, yr_d;
   logic [LEN_W-1:0]  min_len;
   assign swap = orient_q[SWAP_XY_BIT];
   assign min_len = orient_q[MIN_LEN_LSB +: LEN_W];

   always_comb
   begin
      fx_d = first_x_out_q;
      fy_d = first_y_out_q;
      sx_d = second_x_out_q;
      sy_d = second_y_out_q;
      xr_d = x_result_out_q;
      yr_d = y_result_out_q;
      if (sample_valid)
      begin
         fx_d = swap ? first_y_channel : first_x_channel;
         fy_d = swap ? first_x_channel : first_y_channel;
         sx_d = swap ? second_y_channel : second_x_channel;
         sy_d = swap ? second_x_channel : second_y_channel;
         xr_d = negate(x_result, orient_q[FLIP_X_BIT]);
         yr_d = negate(y_result, orient_q[FLIP_Y_BIT]);
      end
      gvalid_d = gesture_done && (gesture_points >= min_len);
      greject_d = gesture_done && (gesture_points < min_len);
   end

   // interrupt pin source and power-down steering
   logic                     fast_div, slow_div, int_pin_d, afe_pd_d;
   logic [PD_COMPONENTS-1:0] pd_out_d;
   logic [TEST_CODE_W-1:0]   test_code;
   edge_divider #(.LOG2_RATIO(FAST_LOG2)) fast_divider (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .source    (fast_oscillator),
      .divided_q (fast_div)
   );

   edge_divider #(.LOG2_RATIO(SLOW_LOG2)) slow_divider (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .source    (slow_oscillator),
      .divided_q (slow_div)
   );

   assign test_code = test_q[TEST_CODE_LSB +: TEST_CODE_W];

   always_comb
   begin
      case (test_code)
         TEST_SLOW:     int_pin_d = slow_oscillator;
         TEST_FAST:     int_pin_d = fast_oscillator;
         TEST_FAST_DIV: int_pin_d = fast_div;
         TEST_SLOW_DIV: int_pin_d = slow_div;
         default:       int_pin_d = normal_int;
      endcase
      for (int c = 0; c < PD_COMPONENTS; c++)
         pd_out_d[c] = pd_q[FORCE_LSB + c] ? pd_q[PD_VALUE_LSB + c] : fsm_power_down[c];
      afe_pd_d = pd_q[AFE_FORCE_BIT] ? afe_logic_power_down : fsm_afe_power_down;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         above_q <= '0;
         below_q <= '0;
         near_enter_event_q <= '0;
         near_exit_event_q <= '0;
         sample_out_valid_q <= 1'b0;
         first_x_out_q <= '0;
         first_y_out_q <= '0;
         second_x_out_q <= '0;
         second_y_out_q <= '0;
         x_result_out_q <= '0;
         y_result_out_q <= '0;
         gesture_valid_q <= 1'b0;
         gesture_reject_q <= 1'b0;
         int_pin_q <= 1'b0;
         fast_osc_trim_enable_q <= 1'b0;
         power_down_q <= '0;
         afe_power_down_q <= 1'b0;
      end
      else
      begin
         above_q <= above_d;
         below_q <= below_d;
         near_enter_event_q <= enter_event_d;
         near_exit_event_q <= exit_event_d;
         sample_out_valid_q <= sample_valid;
         first_x_out_q <= fx_d;
         first_y_out_q <= fy_d;
         second_x_out_q <= sx_d;
         second_y_out_q <= sy_d;
         x_result_out_q <= xr_d;
         y_result_out_q <= yr_d;
         gesture_valid_q <= gvalid_d;
         gesture_reject_q <= greject_d;
         int_pin_q <= int_pin_d;
         fast_osc_trim_enable_q <= test_q[TRIM_ENABLE_BIT];
         power_down_q <= pd_out_d;
         afe_power_down_q <= afe_pd_d;
      end
   end

   flip_x_a: assert property (@(posedge clock) disable iff (sys_rst)
      sample_valid && orient_q[FLIP_X_BIT] |=> x_result_out_q == DATA_W'(-$past(x_result)))
      else $error("x result not negated");
   flip_y_a: assert property (@(posedge clock) disable iff (sys_rst)
      sample_valid && !orient_q[FLIP_Y_BIT] |=> y_result_out_q == $past(y_result))
      else $error("y result altered without flip");
   swap_xy_a: assert property (@(posedge clock) disable iff (sys_rst)
      sample_valid && swap |=> first_x_out_q == $past(first_y_channel) && second_y_out_q == $past(second_x_channel))
      else $error("channels not swapped");
   gesture_len_a: assert property (@(posedge clock) disable iff (sys_rst)
      gesture_done |=> gesture_valid_q == ($past(gesture_points) >= $past(min_len))
         && gesture_valid_q != gesture_reject_q)
      else $error("gesture length check wrong");
   cross_once_a: assert property (@(posedge clock) disable iff (sys_rst)
      intensity_valid && !level_mode && above_q[0] |=> !near_enter_event_q[0])
      else $error("crossing mode repeated event");
   level_repeat_a: assert property (@(posedge clock) disable iff (sys_rst)
      intensity_valid && level_mode && intensity < exit_th[1] |=> near_exit_event_q[1])
      else $error("level mode missed event");
   normal_pin_a: assert property (@(posedge clock) disable iff (sys_rst)
      (test_code == TEST_NORMAL || test_code > TEST_SLOW_DIV) |=> int_pin_q == $past(normal_int))
      else $error("interrupt pin not normal");
   slow_pin_a: assert property (@(posedge clock) disable iff (sys_rst)
      test_code == TEST_SLOW |=> int_pin_q == $past(slow_oscillator))
      else $error("slow oscillator not on pin");
   force_bias_a: assert property (@(posedge clock) disable iff (sys_rst)
      pd_q[FORCE_LSB] |=> power_down_q[0] == $past(pd_q[PD_VALUE_LSB]))
      else $error("forced bias value ignored");
   afe_source_a: assert property (@(posedge clock) disable iff (sys_rst)
      pd_q[AFE_FORCE_BIT] ##1 pd_q[AFE_FORCE_BIT] |-> afe_power_down_q == $past(afe_logic_power_down))
      else $error("front end not on its own logic");
endmodule

// >>> src/gesture_proximity_test_pkg.sv
// constants for the gesture, proximity and test register bank
package gesture_proximity_test_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int THRESH_W = 22;
   localparam int UPPER_W = 6;
   localparam int LEN_W = 8;
   localparam int PD_COMPONENTS = 6;
   localparam int TEST_CODE_W = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_GEST_RATE   = 8'h28;
   localparam logic [ADDR_W-1:0] ADDR_ORIENT      = 8'h29;
   localparam logic [ADDR_W-1:0] ADDR_ENTER1_LOW  = 8'h2A;
   localparam logic [ADDR_W-1:0] ADDR_EXIT1_LOW   = 8'h2B;
   localparam logic [ADDR_W-1:0] ADDR_ENTER2_LOW  = 8'h2C;
   localparam logic [ADDR_W-1:0] ADDR_EXIT2_LOW   = 8'h2D;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL1_UP   = 8'h2E;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL2_UP   = 8'h2F;
   localparam logic [ADDR_W-1:0] ADDR_TEST_SEL    = 8'h30;
   localparam logic [ADDR_W-1:0] ADDR_PD_OVERRIDE = 8'h32;

   // writable bits per register; reserved bits are not stored and read zero
   localparam logic [DATA_W-1:0] MASK_FULL     = 16'hFFFF;
   localparam logic [DATA_W-1:0] MASK_ORIENT   = 16'hFF07;
   localparam logic [DATA_W-1:0] MASK_LEVEL1UP = 16'h3F3F;
   localparam logic [DATA_W-1:0] MASK_LEVEL2UP = 16'hBF3F;
   localparam logic [DATA_W-1:0] MASK_TEST     = 16'h002F;
   localparam logic [DATA_W-1:0] MASK_PD       = 16'h3F7F;

   // reset values
   localparam logic [DATA_W-1:0] RESET_ZERO = 16'h0000;
   localparam logic [DATA_W-1:0] RESET_PD   = 16'h0040;

   // field positions
   localparam int FLIP_X_BIT       = 0;
   localparam int FLIP_Y_BIT       = 1;
   localparam int SWAP_XY_BIT      = 2;
   localparam int MIN_LEN_LSB      = 8;
   localparam int UPPER_ENTER_LSB  = 0;
   localparam int UPPER_EXIT_LSB   = 8;
   localparam int TRIGGER_KIND_BIT = 15;
   localparam int TEST_CODE_LSB    = 0;
   localparam int TRIM_ENABLE_BIT  = 5;
   localparam int FORCE_LSB        = 0;
   localparam int AFE_FORCE_BIT    = 6;
   localparam int PD_VALUE_LSB     = 8;

   // interrupt pin source codes
   localparam logic [TEST_CODE_W-1:0] TEST_NORMAL   = 4'h0;
   localparam logic [TEST_CODE_W-1:0] TEST_SLOW     = 4'h1;
   localparam logic [TEST_CODE_W-1:0] TEST_FAST     = 4'h2;
   localparam logic [TEST_CODE_W-1:0] TEST_FAST_DIV = 4'h3;
   localparam logic [TEST_CODE_W-1:0] TEST_SLOW_DIV = 4'h4;

   // divider ratios as powers of two
   localparam int FAST_DIV_LOG2 = 16;
   localparam int SLOW_DIV_LOG2 = 11;
endpackage

// >>> src/edge_divider.sv
// divides a synchronous square wave by a power of two, counting its rising edges
`timescale 1ns/1ps
module edge_divider #(
   parameter int LOG2_RATIO = 16
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic source,
   output logic      divided_q
);
   logic                  source_prev_q;
   logic                  source_prev_d;
   logic [LOG2_RATIO-2:0] count_q;
   logic [LOG2_RATIO-2:0] count_d;
   logic                  divided_d;

   always_comb
   begin
      source_prev_d = source;
      count_d = count_q;
      divided_d = divided_q;
      if (source && !source_prev_q)
      begin
         count_d = count_q + 1'b1;
         // half a divided period has elapsed
         if (&count_q)
            divided_d = !divided_q;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         source_prev_q <= 1'b0;
         count_q <= '0;
         divided_q <= 1'b0;
      end
      else
      begin
         source_prev_q <= source_prev_d;
         count_q <= count_d;
         divided_q <= divided_d;
      end
   end
endmodule

// >>> tb/host_port_model.sv
// host-side model: register port master and synchronous oscillator sources
`timescale 1ns/1ps
module host_port_model
   import gesture_proximity_test_pkg::*;
(
   input  wire logic              clock,
   output logic      [ADDR_W-1:0] reg_addr,
   output logic      [DATA_W-1:0] reg_wdata,
   output logic                   reg_write,
   output logic                   reg_read,
   input  wire logic [DATA_W-1:0] reg_rdata_q,
   input  wire logic              reg_rvalid_q,
   output logic                   slow_oscillator,
   output logic                   fast_oscillator
);
   logic [1:0] slow_cnt = 2'h0;
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      slow_oscillator = 1'b0;
      fast_oscillator = 1'b0;
   end
   // fast toggles each cycle, slow every fourth
   always @(posedge clock)
   begin
      fast_oscillator <= ~fast_oscillator;
      slow_cnt <= slow_cnt + 2'h1;
      if (slow_cnt == 2'h3)
         slow_oscillator <= ~slow_oscillator;
   end
   // callers leave reserved bits zero
   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1;
      v = reg_rvalid_q;
      d = reg_rdata_q;
   endtask
endmodule

// >>> tb/tb_gesture_proximity_test_regs.sv
// self-checking bench for the gesture, proximity and test register bank
`timescale 1ns/1ps
module tb_gesture_proximity_test_regs
   import gesture_proximity_test_pkg::*;
();
   logic                     clock = 1'b0;
   logic                     sys_rst = 1'b1;
   logic [ADDR_W-1:0]        reg_addr;
   logic [DATA_W-1:0]        reg_wdata, reg_rdata_q, first_x_channel, first_y_channel, second_x_channel;
   logic [DATA_W-1:0]        second_y_channel, x_result, y_result, first_x_out_q, first_y_out_q;
   logic [DATA_W-1:0]        second_x_out_q, second_y_out_q, x_result_out_q, y_result_out_q;
   logic [DATA_W-1:0]        gesture_rate_threshold_q;
   logic                     reg_write, reg_read, reg_rvalid_q, sample_valid, sample_out_valid_q;
   logic                     gesture_done, gesture_valid_q, gesture_reject_q, intensity_valid, normal_int;
   logic                     slow_oscillator, fast_oscillator, int_pin_q, fast_osc_trim_enable_q;
   logic                     fsm_afe_power_down, afe_logic_power_down, afe_power_down_q, want, last;
   logic [LEN_W-1:0]         gesture_points;
   logic [THRESH_W-1:0]      intensity;
   logic [1:0]               near_enter_event_q, near_exit_event_q;
   logic [PD_COMPONENTS-1:0] fsm_power_down, power_down_q;
   logic [THRESH_W-1:0]      ints[7] = '{22'h210011, 22'h210011, 22'h210010, 22'h04FFFF, 22'h04FFFF,
                                         22'h3FFFFF, 22'h000000};
   logic [3:0]               evs[2][7] = '{'{4'h4, 4'h0, 4'h0, 4'h1, 4'h0, 4'hC, 4'h3},
                                           '{4'h4, 4'h4, 4'h0, 4'h1, 4'h1, 4'hC, 4'h3}};
   logic [DATA_W-1:0]        pdv[5] = '{16'h0000, 16'h0040, 16'h3F3F, 16'h1115, 16'h2A7F};
   int                       failures = 0;
   int                       n_tests = 0;
   int                       changes;

   always #20 clock = ~clock;

   host_port_model i_host (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata_q,
      .reg_rvalid_q, .slow_oscillator, .fast_oscillator);

   gesture_proximity_test_regs #(.FAST_LOG2(3), .SLOW_LOG2(2)) i_dut (.clock, .sys_rst, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata_q, .reg_rvalid_q, .sample_valid, .first_x_channel,
      .first_y_channel, .second_x_channel, .second_y_channel, .x_result, .y_result, .sample_out_valid_q,
      .first_x_out_q, .first_y_out_q, .second_x_out_q, .second_y_out_q, .x_result_out_q, .y_result_out_q,
      .gesture_rate_threshold_q, .gesture_done, .gesture_points, .gesture_valid_q, .gesture_reject_q,
      .intensity_valid, .intensity, .near_enter_event_q, .near_exit_event_q, .normal_int,
      .slow_oscillator, .fast_oscillator, .int_pin_q, .fast_osc_trim_enable_q, .fsm_power_down,
      .fsm_afe_power_down, .afe_logic_power_down, .power_down_q, .afe_power_down_q);

   task automatic finish_test;
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      check16({8'h00, got}, {8'h00, exp});
   endtask

   task automatic check_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      logic              v;
      i_host.read_reg(a, d, v);
      check8({7'h00, v}, 8'h01);
      check16(d, exp);
   endtask

   task automatic pulse_sample(input logic [2:0] o);
      @(posedge clock);
      sample_valid <= 1'b1;
      @(posedge clock);
      sample_valid <= 1'b0;
      #1;
      check8({7'h00, sample_out_valid_q}, 8'h01);
      check16(first_x_out_q, o[2] ? 16'h2222 : 16'h1111);
      check16(first_y_out_q, o[2] ? 16'h1111 : 16'h2222);
      check16(second_x_out_q, o[2] ? 16'h4444 : 16'h3333);
      check16(second_y_out_q, o[2] ? 16'h3333 : 16'h4444);
      check16(x_result_out_q, o[0] ? 16'hFFFB : 16'h0005);
      check16(y_result_out_q, o[1] ? 16'h0010 : 16'hFFF0);
   endtask

   task automatic gesture(input logic [7:0] p, input logic [1:0] exp);
      @(posedge clock);
      gesture_done <= 1'b1;
      gesture_points <= p;
      @(posedge clock);
      gesture_done <= 1'b0;
      gesture_points <= ~p;
      #1;
      check8({6'h00, gesture_valid_q, gesture_reject_q}, {6'h00, exp});
   endtask

   task automatic near(input logic [21:0] v, input logic [3:0] exp);
      @(posedge clock);
      intensity_valid <= 1'b1;
      intensity <= v;
      @(posedge clock);
      intensity_valid <= 1'b0;
      intensity <= ~v;
      #1;
      check8({4'h0, near_enter_event_q, near_exit_event_q}, {4'h0, exp});
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      failures++;
      finish_test();
   end

   initial
   begin
      sample_valid = 1'b0;
      first_x_channel = 16'h1111;
      first_y_channel = 16'h2222;
      second_x_channel = 16'h3333;
      second_y_channel = 16'h4444;
      x_result = 16'h0005;
      y_result = 16'hFFF0;
      gesture_done = 1'b0;
      gesture_points = 8'h00;
      intensity_valid = 1'b0;
      intensity = 22'h000000;
      normal_int = 1'b0;
      fsm_power_down = 6'h2A;
      fsm_afe_power_down = 1'b1;
      afe_logic_power_down = 1'b0;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      for (int a = 'h28; a <= 'h32; a++)
         check_read(8'(a), (a == 'h32) ? RESET_PD : RESET_ZERO);
      i_host.write_reg(ADDR_GEST_RATE, 16'hA5C3);
      check_read(ADDR_GEST_RATE, 16'hA5C3);
      check16(gesture_rate_threshold_q, 16'hA5C3);
      for (int o = 0; o < 8; o++)
      begin
         i_host.write_reg(ADDR_ORIENT, {8'h05, 5'h00, 3'(o)});
         pulse_sample(3'(o));
      end
      for (int p = 4; p < 7; p++)
         gesture(8'(p), (p < 5) ? 2'b01 : 2'b10);
      i_host.write_reg(ADDR_ENTER1_LOW, 16'h0010);
      i_host.write_reg(ADDR_EXIT1_LOW, 16'h0000);
      i_host.write_reg(ADDR_ENTER2_LOW, 16'hFFFE);
      i_host.write_reg(ADDR_EXIT2_LOW, 16'h0001);
      i_host.write_reg(ADDR_LEVEL1_UP, 16'h0521);
      check_read(ADDR_LEVEL1_UP, 16'h0521);
      for (int kind = 0; kind < 2; kind++)
      begin
         i_host.write_reg(ADDR_LEVEL2_UP, {1'(kind), 7'h00, 8'h3F});
         check_read(ADDR_LEVEL2_UP, {1'(kind), 7'h00, 8'h3F});
         for (int k = 0; k < 7; k++)
            near(ints[k], evs[kind][k]);
      end
      for (int c = 0; c < 16; c++)
      begin
         i_host.write_reg(ADDR_TEST_SEL, {10'h000, 2'b10, 4'(c)});
         #1;
         changes = 0;
         for (int k = 0; k < 66; k++)
         begin
            want = (c == 1) ? slow_oscillator : (c == 2) ? fast_oscillator : normal_int;
            last = int_pin_q;
            @(posedge clock);
            normal_int <= k[1];
            #1;
            if (c != 3 && c != 4)
               check8({7'h00, int_pin_q}, {7'h00, want});
            else if (k > 1 && int_pin_q != last)
               changes++;
         end
         if (c == 3 || c == 4)
            check8(8'(changes), (c == 3) ? 8'h08 : 8'h04);
         check8({7'h00, fast_osc_trim_enable_q}, 8'h01);
      end
      foreach (pdv[k])
      begin
         i_host.write_reg(ADDR_PD_OVERRIDE, pdv[k]);
         check_read(ADDR_PD_OVERRIDE, pdv[k]);
         check8({2'b00, power_down_q},
                {2'b00, (pdv[k][5:0] & pdv[k][13:8]) | (~pdv[k][5:0] & fsm_power_down)});
         check8({7'h00, afe_power_down_q}, {7'h00, pdv[k][6] ? afe_logic_power_down : fsm_afe_power_down});
      end
      finish_test();
   end
endmodule
